/* cmo_pkg.sv */
package cmo_pkg;
  // register command codes
  localparam logic [7:0] CMO_ADDR_IIN_CMP = 8'h25;
  localparam logic [7:0] CMO_ADDR_SYS_BAT = 8'h26;
  localparam logic [7:0] CMO_ADDR_OPT1 = 8'h30;
  // option register upper byte reset value, low byte held elsewhere
  localparam logic [15:0] CMO_OPT1_RESET = 16'h3300;
  // field positions in the option register
  localparam int CMO_BIT_BATTERY_CURRENT_MONITOR_OUT_EN = 15;
  localparam int CMO_BIT_HOT_LPWR = 14;
  localparam int CMO_BIT_SYSTEM_POWER_MONITOR_OUT_LO = 12;
  localparam int CMO_BIT_RAC = 11;
  localparam int CMO_BIT_RSR = 10;
  localparam int CMO_BIT_RATIO = 9;
  localparam int CMO_BIT_FAST = 8;
  // sensing select encodings
  localparam logic [1:0] CMO_SYSTEM_POWER_MONITOR_OUT_SUM = 2'h0;
  localparam logic [1:0] CMO_SYSTEM_POWER_MONITOR_OUT_BUS = 2'h1;
  localparam logic [1:0] CMO_SYSTEM_POWER_MONITOR_OUT_RSVD = 2'h2;
  localparam logic [1:0] CMO_SYSTEM_POWER_MONITOR_OUT_OFF = 2'h3;
  // result scaling
  localparam logic [15:0] CMO_V_STEP_MV = 16'h0040;
  localparam logic [15:0] CMO_V_BASE_MV = 16'h0b40;
  localparam logic [15:0] CMO_IIN_STEP10_MA = 16'h0032;
  localparam logic [15:0] CMO_IIN_STEP5_MA = 16'h0064;
  // host limit ceilings in 100 mA codes under 5 milliohm sensing
  localparam logic [6:0] CMO_LIMIT_FAST_MAX = 7'h40;
  localparam logic [6:0] CMO_LIMIT_SLOW_MAX = 7'h64;

  // decoded option fields
  typedef struct packed {
    logic battery_current_buffer_enable;
    logic low_power_hot_alert_enable;
    logic [1:0] system_power_sense_select;
    logic input_sense_resistor_select;
    logic charge_sense_resistor_select;
    logic system_power_gain_select;
    logic fast_compensation_enable;
  } cmo_opt_s;

  // one conversion sample from the converter
  typedef struct packed {
    logic [7:0] input_current;
    logic [7:0] comparator_input;
    logic [7:0] system_voltage;
    logic [7:0] battery_voltage;
  } cmo_conv_s;
endpackage

/* cmo_regs.sv */
// How it works
// - input current high byte, comparator low byte
// - system voltage high byte, battery low byte
// - voltages 64 mV steps from 2.88 V
// - input current 50 or 100 mA per step
// - bit 15 battery buffer, off in low power
// - bit 14 low power hot alert enable
// - bits 13-12 power sensing select, reset off
// - low power forces power sensing off
// - bit 10 charge resistor, 0 is 10 milliohm
// - bit 9 power gain, 1 is 1 uA/W
// - fast bit with bit 11 set drops host limit writes above 6.4 A
// - fast bit clear allows limit to 10 A
`timescale 1ns/100ps
`default_nettype none
module cmo_regs
  import cmo_pkg::*;
#(
  parameter int LIMIT_W = 7
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  output logic [15:0] reg_rd_data,
  output logic reg_rd_valid,
  input wire logic conv_valid,
  input wire cmo_conv_s conv_data,
  input wire logic low_power_mode,
  input wire logic limit_wr,
  input wire logic [LIMIT_W-1:0] limit_wdata,
  output logic [LIMIT_W-1:0] host_input_current_limit,
  output cmo_opt_s opt_fields,
  output logic battery_current_monitor_out,
  output logic system_power_monitor_out,
  output logic [1:0] system_power_sense_effective,
  output logic [15:0] input_current_ma,
  output logic [15:0] system_voltage_mv,
  output logic [15:0] battery_voltage_mv
);

  // the clamp comparisons need at least the 100-code range
  if (LIMIT_W < 7 || LIMIT_W > 16) begin : g_width_check
    $error("cmo_regs: LIMIT_W must lie in 7..16");
  end

  // code to millivolts, shared by both voltage results
  function automatic logic [15:0] volt_mv(input logic [7:0] code);
    volt_mv = CMO_V_BASE_MV + 16'({8'h00, code} * CMO_V_STEP_MV);
  endfunction

  cmo_conv_s conv_reg; // last conversion sample
  logic [7:0] opt1_reg; // upper byte of option register
  logic [LIMIT_W-1:0] limit_reg; // accepted host limit
  logic [15:0] rd_data_reg; // read answer
  logic rd_valid_reg; // read answer strobe
  logic [15:0] iin_ma_reg; // scaled input current
  logic [15:0] system_voltage_mv_reg; // scaled system voltage
  logic [15:0] vbat_mv_reg; // scaled battery voltage
  logic wr_opt; // write hits the option register
  logic [LIMIT_W-1:0] limit_max; // current ceiling, 5 milliohm only
  logic limit_ok; // write inside the ceiling

  assign wr_opt = reg_wr && (reg_addr == CMO_ADDR_OPT1);

  // result bytes follow conversions only; bus writes never reach them
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      conv_reg <= '0;
    end else if (conv_valid) begin
      conv_reg <= conv_data;
    end
  end

  // option upper byte; low byte lives in another block
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      opt1_reg <= CMO_OPT1_RESET[15:8];
    end else if (wr_opt) begin
      opt1_reg <= reg_wdata[15:8];
    end
  end

  // field unpack
  always_comb begin
    opt_fields.battery_current_buffer_enable = opt1_reg[CMO_BIT_BATTERY_CURRENT_MONITOR_OUT_EN-8];
    opt_fields.low_power_hot_alert_enable = opt1_reg[CMO_BIT_HOT_LPWR-8];
    opt_fields.system_power_sense_select = opt1_reg[CMO_BIT_SYSTEM_POWER_MONITOR_OUT_LO-8 +: 2];
    opt_fields.input_sense_resistor_select = opt1_reg[CMO_BIT_RAC-8];
    opt_fields.charge_sense_resistor_select = opt1_reg[CMO_BIT_RSR-8];
    opt_fields.system_power_gain_select = opt1_reg[CMO_BIT_RATIO-8];
    opt_fields.fast_compensation_enable = opt1_reg[CMO_BIT_FAST-8];
  end

  // buffers are gated by low power whatever the bits hold
  always_comb begin
    battery_current_monitor_out = opt_fields.battery_current_buffer_enable && !low_power_mode;
    if (low_power_mode) begin
      system_power_sense_effective = CMO_SYSTEM_POWER_MONITOR_OUT_OFF;
    end else begin
      system_power_sense_effective = opt_fields.system_power_sense_select;
    end
    // reserved code treated as off, safest for quiescent current
    system_power_monitor_out = (system_power_sense_effective == CMO_SYSTEM_POWER_MONITOR_OUT_SUM)
      || (system_power_sense_effective == CMO_SYSTEM_POWER_MONITOR_OUT_BUS);
  end

  // ceiling depends on fast compensation; 10 milliohm range (bit 11 clear) takes any code, no ceiling
  always_comb begin
    if (opt_fields.fast_compensation_enable) begin
      limit_max = LIMIT_W'(CMO_LIMIT_FAST_MAX);
    end else begin
      limit_max = LIMIT_W'(CMO_LIMIT_SLOW_MAX);
    end
    limit_ok = !opt_fields.input_sense_resistor_select || (limit_wdata <= limit_max);
  end

  // over-ceiling writes are dropped, old value kept
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      limit_reg <= '0;
    end else if (limit_wr && limit_ok) begin
      limit_reg <= limit_wdata;
    end
  end
  assign host_input_current_limit = limit_reg;

  // scaled results; rescale follows the resistor bit one cycle after the bit changes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      iin_ma_reg <= '0;
      system_voltage_mv_reg <= '0;
      vbat_mv_reg <= '0;
    end else begin
      if (opt_fields.input_sense_resistor_select) begin
        iin_ma_reg <= 16'({8'h00, conv_reg.input_current} * CMO_IIN_STEP5_MA);
      end else begin
        iin_ma_reg <= 16'({8'h00, conv_reg.input_current} * CMO_IIN_STEP10_MA);
      end
      system_voltage_mv_reg <= volt_mv(conv_reg.system_voltage);
      vbat_mv_reg <= volt_mv(conv_reg.battery_voltage);
    end
  end
  assign input_current_ma = iin_ma_reg;
  assign system_voltage_mv = system_voltage_mv_reg;
  assign battery_voltage_mv = vbat_mv_reg;

  // read answer one cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data_reg <= '0;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          CMO_ADDR_IIN_CMP: rd_data_reg <= {conv_reg.input_current, conv_reg.comparator_input};
          CMO_ADDR_SYS_BAT: rd_data_reg <= {conv_reg.system_voltage, conv_reg.battery_voltage};
          CMO_ADDR_OPT1: rd_data_reg <= {opt1_reg, 8'h00};
          default: rd_data_reg <= '0;
        endcase
      end
    end
  end
  assign reg_rd_data = rd_data_reg;
  assign reg_rd_valid = rd_valid_reg;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_read(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence

  // every result check looks back one edge, since the answer is registered
  a_iin_read_layout: assert property (s_read(CMO_ADDR_IIN_CMP) |=>
    reg_rd_valid && reg_rd_data == {$past(conv_reg.input_current), $past(conv_reg.comparator_input)})
    else $error("input current read layout wrong");
  a_volt_read_layout: assert property (s_read(CMO_ADDR_SYS_BAT) |=>
    reg_rd_valid && reg_rd_data == {$past(conv_reg.system_voltage), $past(conv_reg.battery_voltage)})
    else $error("voltage read layout wrong");
  a_system_voltage_scale: assert property ($stable(conv_reg) |=>
    system_voltage_mv == CMO_V_BASE_MV + 16'({8'h00, $past(conv_reg.system_voltage)} * CMO_V_STEP_MV))
    else $error("system voltage scaling wrong");
  a_vbat_scale: assert property ($stable(conv_reg) |=>
    battery_voltage_mv == CMO_V_BASE_MV + 16'({8'h00, $past(conv_reg.battery_voltage)} * CMO_V_STEP_MV))
    else $error("battery voltage scaling wrong");
  // scale follows the resistor bit as it stood at the sampling edge
  a_iin_scale: assert property ($stable(conv_reg) && $stable(opt1_reg) |=>
    input_current_ma == 16'({8'h00, $past(conv_reg.input_current)}
    * ($past(opt_fields.input_sense_resistor_select) ? CMO_IIN_STEP5_MA : CMO_IIN_STEP10_MA)))
    else $error("input current scaling wrong");
  a_battery_current_monitor_out_lowpower: assert property (low_power_mode |-> !battery_current_monitor_out)
    else $error("battery buffer on in low power");
  a_system_power_monitor_out_lowpower: assert property (low_power_mode |-> !system_power_monitor_out
    && system_power_sense_effective == CMO_SYSTEM_POWER_MONITOR_OUT_OFF)
    else $error("power sensing on in low power");
  a_system_power_monitor_out_reserved: assert property (!low_power_mode && opt_fields.system_power_sense_select == CMO_SYSTEM_POWER_MONITOR_OUT_RSVD |->
    !system_power_monitor_out)
    else $error("reserved sensing code left sensing on");
  a_opt_read: assert property (s_read(CMO_ADDR_OPT1) |=>
    reg_rd_valid && reg_rd_data == {$past(opt1_reg), 8'h00})
    else $error("option read layout wrong");
  a_opt_write: assert property (wr_opt |=> opt_fields.system_power_sense_select == $past(reg_wdata[13:12])
    && opt_fields.battery_current_buffer_enable == $past(reg_wdata[15]))
    else $error("option write not stored");
  a_fast_clamp: assert property (limit_wr && opt1_reg[3] && opt1_reg[0] && limit_wdata > 7'h40 |=>
    $stable(host_input_current_limit))
    else $error("fast clamp let limit above 6.4 A");
  a_slow_clamp: assert property (limit_wr && opt1_reg[3] && !opt1_reg[0] && limit_wdata <= 7'h64 |=>
    host_input_current_limit == $past(limit_wdata))
    else $error("limit up to 10 A refused");
  a_result_hold: assert property (!conv_valid |=> $stable(conv_reg))
    else $error("result changed without conversion");

endmodule // cmo_regs
`default_nettype wire

/* cmo_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// host side of the register port, one request at a time
module cmo_host_model (
  input wire logic sys_clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  output logic reg_rd,
  input wire logic [15:0] reg_rd_data,
  input wire logic reg_rd_valid
);
  // idle lines before the first request
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd = 1'b0;
  end
  // word write; released lines show inverted values so stale data is never mistaken
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk) #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // read pulse; answer taken in the cycle after the request
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
    @(posedge sys_clk) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk) #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rd_data;
    v = reg_rd_valid;
  endtask
endmodule // cmo_host_model
`default_nettype wire

/* tb_charger_monitor_option_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_charger_monitor_option_regs;
  import cmo_pkg::*;
  // inputs driven by the bench
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic conv_valid = 1'b0;
  cmo_conv_s conv_data = '0;
  logic low_power_mode = 1'b0;
  logic limit_wr = 1'b0;
  logic [6:0] limit_wdata = 7'h00;
  // register port and design outputs
  logic [7:0] reg_addr;
  logic reg_wr, reg_rd, reg_rd_valid, battery_current_monitor_out, system_power_monitor_out;
  logic [15:0] reg_wdata, reg_rd_data, input_current_ma, system_voltage_mv, battery_voltage_mv;
  logic [6:0] host_input_current_limit;
  logic [1:0] system_power_sense_effective;
  cmo_opt_s opt_fields;
  int err_count = 0;
  int checks = 0;
  // 40 MHz clock
  always #12.5 sys_clk = ~sys_clk;
  cmo_host_model u_cmo_host_model (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid));
  cmo_regs u_cmo_regs (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
    .conv_valid(conv_valid), .conv_data(conv_data), .low_power_mode(low_power_mode),
    .limit_wr(limit_wr), .limit_wdata(limit_wdata), .host_input_current_limit(host_input_current_limit),
    .opt_fields(opt_fields), .battery_current_monitor_out(battery_current_monitor_out),
    .system_power_monitor_out(system_power_monitor_out),
    .system_power_sense_effective(system_power_sense_effective), .input_current_ma(input_current_ma),
    .system_voltage_mv(system_voltage_mv), .battery_voltage_mv(battery_voltage_mv));
  // edges, then the usual drive delay
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // read one word and judge both valid and data
  task automatic rdchk(input string n, input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic v;
    u_cmo_host_model.rd(a, d, v);
    chk("rd valid", 16'h0001, {15'h0, v});
    chk(n, e, d);
  endtask
  // limit write, then the accepted code
  task automatic lim(input logic [6:0] c, input logic [6:0] e);
    limit_wdata = c;
    limit_wr = 1'b1;
    tick(1);
    limit_wr = 1'b0;
    tick(1);
    chk("limit", {9'h0, e}, {9'h0, host_input_current_limit});
  endtask
  task automatic t_reset;
    rdchk("opt reset", CMO_ADDR_OPT1, 16'h3300);
    chk("sense eff", 16'h0003, {14'h0, system_power_sense_effective});
    chk("battery_current_monitor_out out", 16'h0000, {15'h0, battery_current_monitor_out});
  endtask
  // one sample, then results, scaling and write protection
  task automatic t_conv;
    conv_data = {8'h5a, 8'h3c, 8'hc3, 8'h2d};
    conv_valid = 1'b1;
    tick(1);
    conv_valid = 1'b0;
    tick(2);
    rdchk("iin cmp", CMO_ADDR_IIN_CMP, 16'h5a3c);
    rdchk("sys bat", CMO_ADDR_SYS_BAT, 16'hc32d);
    chk("system_voltage mv", 16'h0b40 + 16'h00c3 * 16'h0040, system_voltage_mv);
    chk("vbat mv", 16'h0b40 + 16'h002d * 16'h0040, battery_voltage_mv);
    chk("iin 10", 16'h005a * 16'h0032, input_current_ma);
    u_cmo_host_model.wr(CMO_ADDR_OPT1, 16'h3b00);
    tick(2);
    chk("iin 5", 16'h005a * 16'h0064, input_current_ma);
    u_cmo_host_model.wr(CMO_ADDR_IIN_CMP, 16'hffff);
    u_cmo_host_model.wr(CMO_ADDR_SYS_BAT, 16'h0000);
    rdchk("ro iin", CMO_ADDR_IIN_CMP, 16'h5a3c);
    rdchk("ro sys", CMO_ADDR_SYS_BAT, 16'hc32d);
    rdchk("unmapped", 8'h40, 16'h0000);
  endtask
  // every sensing code, with and without low power
  task automatic t_opt;
    logic [1:0] s;
    for (int i = 0; i < 4; i++) begin
      s = i[1:0];
      u_cmo_host_model.wr(CMO_ADDR_OPT1, {2'b11, s, 4'b0101, 8'hff});
      rdchk("opt", CMO_ADDR_OPT1, {2'b11, s, 4'b0101, 8'h00});
      chk("fields", {8'h00, 2'b11, s, 4'b0101}, {8'h00, opt_fields});
      chk("eff", {14'h0, s}, {14'h0, system_power_sense_effective});
      chk("system_power_monitor_out", {15'h0, s[1] == 1'b0}, {15'h0, system_power_monitor_out});
      chk("battery_current_monitor_out", 16'h0001, {15'h0, battery_current_monitor_out});
      low_power_mode = 1'b1;
      tick(1);
      chk("lp eff", 16'h0003, {14'h0, system_power_sense_effective});
      chk("lp system_power_monitor_out", 16'h0000, {15'h0, system_power_monitor_out});
      chk("lp battery_current_monitor_out", 16'h0000, {15'h0, battery_current_monitor_out});
      low_power_mode = 1'b0;
    end
  endtask
  // clamp at the boundary codes of both compensation settings
  task automatic t_limit;
    u_cmo_host_model.wr(CMO_ADDR_OPT1, 16'h0900);
    lim(7'h40, 7'h40);
    lim(7'h41, 7'h40);
    u_cmo_host_model.wr(CMO_ADDR_OPT1, 16'h0800);
    lim(7'h64, 7'h64);
    lim(7'h65, 7'h64);
  endtask
  // reset in mid-run brings back defaults and the voltage base
  task automatic t_rst_mid;
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(2);
    chk("rst limit", 16'h0000, {9'h0, host_input_current_limit});
    chk("rst system_voltage", 16'h0b40, system_voltage_mv);
    chk("rst vbat", 16'h0b40, battery_voltage_mv);
    chk("rst iin", 16'h0000, input_current_ma);
    rdchk("rst iin cmp", CMO_ADDR_IIN_CMP, 16'h0000);
    rdchk("rst opt", CMO_ADDR_OPT1, 16'h3300);
  endtask
  task automatic report_and_stop;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // main sequence after a ten-cycle reset
  initial begin
    tick(10);
    rst = 1'b0;
    t_reset();
    t_conv();
    t_opt();
    t_limit();
    t_rst_mid();
    report_and_stop();
  end
  // watchdog at 3000 cycles, far beyond the 73 cycles needed
  initial begin
    #75000;
    err_count++;
    report_and_stop();
  end
endmodule // tb_charger_monitor_option_regs
`default_nettype wire
